//--- hw/bat_pkg.sv
// Shared constants and types for the byte ALU with machine-cycle timing
package bat_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned PTR_W   = 16;
  localparam int unsigned WS_W    = 3;
  localparam int unsigned DIV_W   = 3;
  localparam int unsigned MCLEN_W = 11;
  localparam int unsigned LEN_W   = 2;
  localparam int unsigned CYC_W   = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: native core clocks per machine cycle with no wait state, divide by 1
  localparam int unsigned          CORE_CLK_HZ  = 10000000;
  localparam logic [MCLEN_W-1:0]   MC_BASE_CLKS = 11'h004;

  // Encoded lengths in bytes and execution times in machine cycles
  localparam logic [LEN_W-1:0] LEN_ONE   = 2'h1;
  localparam logic [LEN_W-1:0] LEN_TWO   = 2'h2;
  localparam logic [LEN_W-1:0] LEN_THREE = 2'h3;
  localparam logic [CYC_W-1:0] CYC_ONE   = 3'h1;
  localparam logic [CYC_W-1:0] CYC_TWO   = 3'h2;
  localparam logic [CYC_W-1:0] CYC_FOUR  = 3'h4;

  // Decimal adjust constants
  localparam logic [DATA_W-1:0] BCD_LO_FIX    = 8'h06;
  localparam logic [DATA_W-1:0] BCD_HI_FIX    = 8'h60;
  localparam logic [DATA_W-1:0] BCD_BYTE_MAX  = 8'h99;
  localparam logic [3:0]        BCD_DIGIT_MAX = 4'h9;

  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [PTR_W-1:0]  PTR_RST  = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Operations, operand sources and control states
  typedef enum logic [3:0] {
    OP_ADD                  = 4'h0,
    OP_SUM_WITH_CARRY_IN    = 4'h1,
    OP_SUBTRACT_WITH_BORROW = 4'h2,
    OP_PLUS_ONE             = 4'h3,
    OP_MINUS_ONE            = 4'h4,
    OP_POINTER_PLUS_ONE     = 4'h5,
    OP_PRODUCT_AB           = 4'h6,
    OP_QUOTIENT_AB          = 4'h7,
    OP_BCD_CORRECT          = 4'h8,
    OP_BITWISE_AND          = 4'h9,
    OP_BITWISE_OR           = 4'hA,
    OP_BITWISE_XOR          = 4'hB,
    OP_NIBBLE_SWAP          = 4'hC
  } bat_op_t;

  typedef enum logic [2:0] {
    SRC_BANK      = 3'h0,
    SRC_DIRECT    = 3'h1,
    SRC_INDIRECT  = 3'h2,
    SRC_IMMEDIATE = 3'h3,
    SRC_MAIN      = 3'h4
  } bat_src_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } bat_state_t;

endpackage : bat_pkg

//--- hw/bat_mcycle_timer.sv
// Machine-cycle timer: counts core clocks of one machine cycle, holds on stalls
`timescale 1ns/1ps
`default_nettype none

module bat_mcycle_timer (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        run,
  input  wire logic [bat_pkg::MCLEN_W-1:0] native_len,
  input  wire logic                        stall,
  output logic                             mc_end
);

  logic [bat_pkg::MCLEN_W-1:0] count_r;
  logic [bat_pkg::MCLEN_W-1:0] count_nxt;
  logic                        last_clk;

  ////////////////////////////////////////////////////////////////////////////
  // A stall freezes the count, so the current machine cycle grows by one clock per stalled clock
  assign last_clk  = (count_r == native_len - bat_pkg::MCLEN_W'(1));
  assign mc_end    = run & ~stall & last_clk;
  assign count_nxt = !run    ? '0 :
                     stall   ? count_r :
                     last_clk ? '0 : count_r + bat_pkg::MCLEN_W'(1);

  // Count register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule : bat_mcycle_timer

`default_nettype wire

//--- hw/bat_core.sv
// Byte ALU for the arithmetic and logical group, timed in machine cycles
`timescale 1ns/1ps
`default_nettype none

// Function
// - Each operation reports its byte length and its count of machine cycles
// - Native machine cycle set by wait states and divider, four clocks by default
// - A prefetch queue stall stretches the current machine cycle
// - A branch cache miss stretches the current machine cycle
// - Without stall or miss every machine cycle keeps its native length
// - Plain add: one cycle; bank/indirect one byte, direct/immediate two bytes
// - Add with carry-in: all four sources, one cycle, one or two bytes
// - Subtract with borrow: all four sources, one cycle each
// - AND into main operand from any of four sources takes one cycle
// - AND into direct byte: from main one cycle two bytes, immediate two/three
// - OR into main operand from any of four sources takes one cycle
// - OR of main operand into direct byte: one cycle, two bytes
// - OR of immediate into direct byte: two cycles, three bytes
// - XOR into main operand: direct two bytes, bank one byte, one cycle
// - Nibble swap of main operand: one byte, one cycle
module bat_core (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        start,
  input  wire bat_pkg::bat_op_t            op_sel,
  input  wire bat_pkg::bat_src_t           src_sel,
  input  wire logic                        to_direct,
  input  wire logic [bat_pkg::DATA_W-1:0]  main_operand_in,
  input  wire logic [bat_pkg::DATA_W-1:0]  src_data,
  input  wire logic [bat_pkg::DATA_W-1:0]  direct_byte_in,
  input  wire logic [bat_pkg::DATA_W-1:0]  aux_operand_in,
  input  wire logic [bat_pkg::PTR_W-1:0]   data_pointer16_in,
  input  wire logic                        carry_in,
  input  wire logic                        aux_carry_in,
  input  wire logic                        overflow_in,
  input  wire logic [bat_pkg::WS_W-1:0]    bus_wait_config,
  input  wire logic [bat_pkg::DIV_W-1:0]   clock_divider_config,
  input  wire logic                        prefetch_queue_stall,
  input  wire logic                        branch_cache_miss,
  output logic                             busy_r,
  output logic                             done_r,
  output logic [bat_pkg::DATA_W-1:0]       result_r,
  output logic [bat_pkg::DATA_W-1:0]       aux_result_r,
  output logic [bat_pkg::PTR_W-1:0]        data_pointer16_r,
  output logic                             carry_r,
  output logic                             aux_carry_r,
  output logic                             overflow_r,
  output logic                             write_direct_r,
  output logic [bat_pkg::LEN_W-1:0]        instr_len_r,
  output logic [bat_pkg::CYC_W-1:0]        instr_cycles_r,
  output logic                             mcycle_end_r,
  output logic                             stretch_r
);

  localparam int unsigned DW = bat_pkg::DATA_W;
  localparam int unsigned RW = 2 * bat_pkg::DATA_W + 3;

  ////////////////////////////////////////////////////////////////////////////
  // Byte length and machine cycles of an operation, packed {len, cycles}
  function automatic logic [bat_pkg::LEN_W+bat_pkg::CYC_W-1:0] op_timing(
    input bat_pkg::bat_op_t  op,
    input bat_pkg::bat_src_t src,
    input logic              dst_direct
  );
    logic [bat_pkg::LEN_W-1:0] len;
    logic [bat_pkg::CYC_W-1:0] cyc;
    logic                      wide;
    wide = (src == bat_pkg::SRC_DIRECT) || (src == bat_pkg::SRC_IMMEDIATE);
    len  = wide ? bat_pkg::LEN_TWO : bat_pkg::LEN_ONE;
    cyc  = bat_pkg::CYC_ONE;
    case (op)
      bat_pkg::OP_POINTER_PLUS_ONE: begin
        len = bat_pkg::LEN_ONE;
        cyc = bat_pkg::CYC_TWO;
      end
      bat_pkg::OP_PRODUCT_AB, bat_pkg::OP_QUOTIENT_AB: begin
        len = bat_pkg::LEN_ONE;
        cyc = bat_pkg::CYC_FOUR;
      end
      bat_pkg::OP_BCD_CORRECT, bat_pkg::OP_NIBBLE_SWAP: begin
        len = bat_pkg::LEN_ONE;
      end
      bat_pkg::OP_BITWISE_AND, bat_pkg::OP_BITWISE_OR, bat_pkg::OP_BITWISE_XOR: begin
        if (dst_direct) begin
          len = (src == bat_pkg::SRC_IMMEDIATE) ? bat_pkg::LEN_THREE : bat_pkg::LEN_TWO;
          cyc = (src == bat_pkg::SRC_IMMEDIATE) ? bat_pkg::CYC_TWO : bat_pkg::CYC_ONE;
        end
      end
      default: begin
        len = len; // Add, subtract and inc/dec take two bytes with a direct or immediate source
      end
    endcase
    return {len, cyc};
  endfunction : op_timing

  ////////////////////////////////////////////////////////////////////////////
  // Data result, packed {ov, ac, cy, hi byte, lo byte}
  function automatic logic [RW-1:0] alu_eval(
    input bat_pkg::bat_op_t op,
    input logic [DW-1:0]    a,
    input logic [DW-1:0]    b,
    input logic             cin,
    input logic             acin,
    input logic             ovin
  );
    logic [DW:0]     s9;
    logic [4:0]      n5;
    logic [2*DW-1:0] p16;
    logic [DW-1:0]   lo;
    logic [DW-1:0]   hi;
    logic            cy;
    logic            ac;
    logic            ov;
    logic            ci;
    lo = a;
    hi = b;
    cy = cin;
    ac = acin;
    ov = ovin;
    ci = (op == bat_pkg::OP_ADD) ? 1'b0 : cin;
    case (op)
      bat_pkg::OP_ADD, bat_pkg::OP_SUM_WITH_CARRY_IN: begin
        s9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        n5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        lo = s9[DW-1:0];
        cy = s9[DW];
        ac = n5[4];
        ov = (a[DW-1] == b[DW-1]) && (lo[DW-1] != a[DW-1]);
      end
      bat_pkg::OP_SUBTRACT_WITH_BORROW: begin
        s9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        n5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        lo = s9[DW-1:0];
        cy = s9[DW];
        ac = n5[4];
        ov = (a[DW-1] != b[DW-1]) && (lo[DW-1] != a[DW-1]);
      end
      bat_pkg::OP_PLUS_ONE:  lo = a + 8'h01;
      bat_pkg::OP_MINUS_ONE: lo = a - 8'h01;
      bat_pkg::OP_PRODUCT_AB: begin
        p16 = {8'h00, a} * {8'h00, b};
        lo  = p16[DW-1:0];
        hi  = p16[2*DW-1:DW];
        cy  = 1'b0;
        ov  = (hi != 8'h00);
      end
      bat_pkg::OP_QUOTIENT_AB: begin
        cy = 1'b0;
        ov = (b == 8'h00); // Divide by zero leaves both bytes untouched
        if (b != 8'h00) begin
          lo = a / b;
          hi = a % b;
        end
      end
      bat_pkg::OP_BCD_CORRECT: begin
        s9 = {1'b0, a};
        if ((a[3:0] > bat_pkg::BCD_DIGIT_MAX) || acin) begin
          s9 = s9 + {1'b0, bat_pkg::BCD_LO_FIX};
        end
        if ((a > bat_pkg::BCD_BYTE_MAX) || cin || s9[DW]) begin
          s9 = s9 + {1'b0, bat_pkg::BCD_HI_FIX};
          cy = 1'b1;
        end else if (s9[DW-1:4] > bat_pkg::BCD_DIGIT_MAX) begin
          s9 = s9 + {1'b0, bat_pkg::BCD_HI_FIX};
          cy = 1'b1;
        end
        lo = s9[DW-1:0];
      end
      bat_pkg::OP_BITWISE_AND: lo = a & b;
      bat_pkg::OP_BITWISE_OR:  lo = a | b;
      bat_pkg::OP_BITWISE_XOR: lo = a ^ b;
      bat_pkg::OP_NIBBLE_SWAP: lo = {a[3:0], a[DW-1:4]};
      default: lo = a;
    endcase
    return {ov, ac, cy, hi, lo};
  endfunction : alu_eval

  ////////////////////////////////////////////////////////////////////////////
  // Operand selection: direct-destination forms use the direct byte as target
  wire logic                 logic_op;
  wire logic                 dst_direct;
  wire logic                 step_op;
  wire logic [DW-1:0]        opnd_a;
  wire logic [DW-1:0]        opnd_b;
  wire logic [RW-1:0]        alu_out;
  wire logic [bat_pkg::LEN_W+bat_pkg::CYC_W-1:0] timing;

  assign logic_op   = (op_sel == bat_pkg::OP_BITWISE_AND) ||
                      (op_sel == bat_pkg::OP_BITWISE_OR)  ||
                      (op_sel == bat_pkg::OP_BITWISE_XOR);
  assign step_op    = (op_sel == bat_pkg::OP_PLUS_ONE) || (op_sel == bat_pkg::OP_MINUS_ONE);
  assign dst_direct = logic_op & to_direct;
  assign opnd_a     = dst_direct ? direct_byte_in :
                      (step_op && (src_sel != bat_pkg::SRC_MAIN)) ? src_data :
                      main_operand_in;
  assign opnd_b     = (op_sel == bat_pkg::OP_PRODUCT_AB) ? aux_operand_in :
                      (op_sel == bat_pkg::OP_QUOTIENT_AB) ? aux_operand_in :
                      (dst_direct && (src_sel != bat_pkg::SRC_IMMEDIATE)) ? main_operand_in :
                      src_data;
  assign alu_out    = alu_eval(op_sel, opnd_a, opnd_b, carry_in, aux_carry_in, overflow_in);
  assign timing     = op_timing(op_sel, src_sel, dst_direct);

  ////////////////////////////////////////////////////////////////////////////
  // Native machine cycle: base clocks plus wait states, scaled by the divider
  wire logic [bat_pkg::MCLEN_W-1:0] native_len_w;
  wire logic                        stall_w;
  wire logic                        mc_end_w;
  logic [bat_pkg::MCLEN_W-1:0]      native_len_r;

  assign native_len_w = (bat_pkg::MC_BASE_CLKS + bat_pkg::MCLEN_W'(bus_wait_config))
                        << clock_divider_config;
  // Either stall source holds the timer; neither leaves the cycle native
  assign stall_w      = prefetch_queue_stall | branch_cache_miss;

  ////////////////////////////////////////////////////////////////////////////
  // Control state machine
  bat_pkg::bat_state_t          state_r;
  bat_pkg::bat_state_t          state_nxt;
  logic [bat_pkg::CYC_W-1:0]    left_r;
  wire logic                    accept;
  wire logic                    last_mc;

  assign accept  = start && (state_r == bat_pkg::ST_IDLE);
  assign last_mc = mc_end_w && (left_r == bat_pkg::CYC_ONE);

  always_comb begin
    case (state_r)
      bat_pkg::ST_IDLE: state_nxt = start ? bat_pkg::ST_EXEC : bat_pkg::ST_IDLE;
      bat_pkg::ST_EXEC: state_nxt = last_mc ? bat_pkg::ST_DONE : bat_pkg::ST_EXEC;
      bat_pkg::ST_DONE: state_nxt = bat_pkg::ST_IDLE;
      default:          state_nxt = bat_pkg::ST_IDLE;
    endcase
  end

  bat_mcycle_timer u_timer (
    .core_clk   (core_clk),
    .rst        (rst),
    .run        (state_r == bat_pkg::ST_EXEC),
    .native_len (native_len_r),
    .stall      (stall_w),
    .mc_end     (mc_end_w)
  );

  // State, machine-cycle countdown and per-cycle status
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r      <= bat_pkg::ST_IDLE;
      left_r       <= '0;
      native_len_r <= bat_pkg::MC_BASE_CLKS;
      mcycle_end_r <= 1'b0;
      stretch_r    <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      mcycle_end_r <= mc_end_w;
      stretch_r    <= (state_r == bat_pkg::ST_EXEC) && stall_w;
      if (accept) begin
        left_r       <= timing[bat_pkg::CYC_W-1:0];
        native_len_r <= native_len_w; // Settings frozen for the whole instruction
      end else if (mc_end_w) begin
        left_r <= left_r - bat_pkg::CYC_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Results are latched at acceptance and held; done marks the end of the count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_r           <= 1'b0;
      done_r           <= 1'b0;
      result_r         <= bat_pkg::DATA_RST;
      aux_result_r     <= bat_pkg::DATA_RST;
      data_pointer16_r <= bat_pkg::PTR_RST;
      carry_r          <= 1'b0;
      aux_carry_r      <= 1'b0;
      overflow_r       <= 1'b0;
      write_direct_r   <= 1'b0;
      instr_len_r      <= '0;
      instr_cycles_r   <= '0;
    end else begin
      busy_r <= (state_nxt == bat_pkg::ST_EXEC);
      done_r <= last_mc && (state_r == bat_pkg::ST_EXEC);
      if (accept) begin
        result_r         <= alu_out[DW-1:0];
        aux_result_r     <= alu_out[2*DW-1:DW];
        carry_r          <= alu_out[2*DW];
        aux_carry_r      <= alu_out[2*DW+1];
        overflow_r       <= alu_out[2*DW+2];
        data_pointer16_r <= (op_sel == bat_pkg::OP_POINTER_PLUS_ONE) ?
                            data_pointer16_in + bat_pkg::PTR_W'(1) : data_pointer16_in;
        write_direct_r   <= dst_direct;
        instr_len_r      <= timing[bat_pkg::LEN_W+bat_pkg::CYC_W-1:bat_pkg::CYC_W];
        instr_cycles_r   <= timing[bat_pkg::CYC_W-1:0];
      end
    end
  end

endmodule : bat_core

`default_nettype wire

//--- tb/bat_core_asserts.sv
// Concurrent checks on the ports of the machine-cycle timed byte ALU
`timescale 1ns/1ps
`default_nettype none

module bat_core_asserts (
  input wire logic                        core_clk,
  input wire logic                        rst,
  input wire logic                        start,
  input wire bat_pkg::bat_op_t            op_sel,
  input wire bat_pkg::bat_src_t           src_sel,
  input wire logic [bat_pkg::DATA_W-1:0]  main_operand_in,
  input wire logic [bat_pkg::WS_W-1:0]    bus_wait_config,
  input wire logic [bat_pkg::DIV_W-1:0]   clock_divider_config,
  input wire logic                        prefetch_queue_stall,
  input wire logic                        branch_cache_miss,
  input wire logic                        busy_r,
  input wire logic                        done_r,
  input wire logic [bat_pkg::DATA_W-1:0]  result_r,
  input wire logic [bat_pkg::LEN_W-1:0]   instr_len_r,
  input wire logic [bat_pkg::CYC_W-1:0]   instr_cycles_r,
  input wire logic                        mcycle_end_r,
  input wire logic                        stretch_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Helper decode: a request is only taken while idle
  wire logic take = start && !busy_r && !done_r;
  wire logic held = prefetch_queue_stall || branch_cache_miss;
  logic [bat_pkg::DATA_W-1:0] main_q;

  // Keeps the operand of the taking edge for the swap check
  always_ff @(posedge core_clk) main_q <= main_operand_in;

  ////////////////////////////////////////////////////////////////////////////
  // Handshake, timing and the nibble swap value
  chk_done_one_cycle: assert property (done_r |=> !done_r)
    else $error("done held longer than one clock");
  chk_busy_ends_done: assert property ($fell(busy_r) |-> done_r)
    else $error("busy dropped without done");
  chk_take_sets_busy: assert property (take |=> busy_r)
    else $error("accepted request did not raise busy");
  chk_result_stands: assert property (busy_r ##1 busy_r |-> $stable(result_r))
    else $error("result moved during execution");
  chk_native_four: assert property ((take && bus_wait_config == 3'h0 &&
    clock_divider_config == 3'h0) ##1 (instr_cycles_r == bat_pkg::CYC_ONE && !held)[*4]
    |=> done_r)
    else $error("one native cycle did not last four clocks");
  chk_mcend_at_done: assert property ($rose(done_r) |-> mcycle_end_r)
    else $error("no machine cycle end with done");
  chk_stall_holds: assert property (busy_r && held |=> !done_r)
    else $error("cycle advanced during a stall");
  chk_stall_flag: assert property (busy_r && held |=> stretch_r)
    else $error("stretch flag missing after stall");
  chk_add_two_byte: assert property (take && op_sel == bat_pkg::OP_ADD &&
    (src_sel == bat_pkg::SRC_DIRECT || src_sel == bat_pkg::SRC_IMMEDIATE)
    |=> instr_len_r == bat_pkg::LEN_TWO && instr_cycles_r == bat_pkg::CYC_ONE)
    else $error("wide add length or time wrong");
  chk_mul_four: assert property (take && op_sel == bat_pkg::OP_PRODUCT_AB
    |=> instr_cycles_r == bat_pkg::CYC_FOUR && instr_len_r == bat_pkg::LEN_ONE)
    else $error("multiply length or time wrong");
  chk_swap_value: assert property (take && op_sel == bat_pkg::OP_NIBBLE_SWAP
    |=> result_r == {main_q[3:0], main_q[7:4]})
    else $error("nibble swap value wrong");

  // Main scenarios reached
  cov_multiply: cover property (take && op_sel == bat_pkg::OP_PRODUCT_AB);
  cov_queue_stall: cover property (busy_r && prefetch_queue_stall);
  cov_cache_miss: cover property (busy_r && branch_cache_miss);
endmodule : bat_core_asserts

`default_nettype wire

//--- tb/tb_bat_core.sv
// Self-checking bench for the machine-cycle timed byte ALU
`timescale 1ns/1ps
`default_nettype none

module tb_bat_core;
  logic core_clk, rst, start, to_direct, carry_in, aux_carry_in, overflow_in;
  logic prefetch_queue_stall, branch_cache_miss, busy_r, done_r, carry_r, aux_carry_r;
  logic overflow_r, write_direct_r, mcycle_end_r, stretch_r;
  bat_pkg::bat_op_t  op_sel;
  bat_pkg::bat_src_t src_sel;
  logic [7:0]  main_operand_in, src_data, direct_byte_in, aux_operand_in, result_r, aux_result_r;
  logic [15:0] data_pointer16_in, data_pointer16_r;
  logic [2:0]  bus_wait_config, clock_divider_config, instr_cycles_r;
  logic [1:0]  instr_len_r;
  int          n_fail, check_count, k;
  logic        poke, bc_sel;

  bat_core DUT (
    .core_clk, .rst, .start, .op_sel, .src_sel, .to_direct, .main_operand_in, .src_data,
    .direct_byte_in, .aux_operand_in, .data_pointer16_in, .carry_in, .aux_carry_in,
    .overflow_in, .bus_wait_config, .clock_divider_config, .prefetch_queue_stall,
    .branch_cache_miss, .busy_r, .done_r, .result_r, .aux_result_r, .data_pointer16_r,
    .carry_r, .aux_carry_r, .overflow_r, .write_direct_r, .instr_len_r, .instr_cycles_r,
    .mcycle_end_r, .stretch_r
  );

  // 10 MHz core clock
  always #50 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////
  // One operation: stalls of k clocks and a stray request are optional
  task automatic go(input bat_pkg::bat_op_t op, input bat_pkg::bat_src_t src, input logic dir,
                    input logic [7:0] a, s, d, input logic [1:0] el, input logic [2:0] ec,
                    input logic [7:0] er);
    int n;
    int exp_n;
    @(posedge core_clk);
    // Read settings once they have landed; done shows N*L edges after the taking edge
    exp_n = int'(ec) * ((int'(bat_pkg::MC_BASE_CLKS) + int'(bus_wait_config))
            << clock_divider_config) + 1 + k;
    start <= 1'b1;
    op_sel <= op;
    src_sel <= src;
    to_direct <= dir;
    main_operand_in <= a;
    src_data <= s;
    direct_byte_in <= d;
    n = 0;
    while (n < 1000) begin
      @(posedge core_clk);
      n++;
      start <= poke && n == 2; // Stray request while busy must be dropped
      if (poke && n == 2) main_operand_in <= ~a;
      prefetch_queue_stall <= !bc_sel && n >= 2 && n < 2 + k;
      branch_cache_miss <= bc_sel && n >= 2 && n < 2 + k;
      @(negedge core_clk);
      if (n == 2) chk(busy_r, 1'b1);
      if (done_r === 1'b1) break;
    end
    chk(16'(n), 16'(exp_n));
    chk(instr_len_r, el);
    chk(instr_cycles_r, ec);
    if (!$isunknown(er)) chk(result_r, er);
  endtask : go

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator forms of add, add with carry, subtract, and, or, xor over four sources
  task automatic t_arith;
    bat_pkg::bat_op_t ops [6] = '{bat_pkg::OP_ADD, bat_pkg::OP_SUM_WITH_CARRY_IN,
      bat_pkg::OP_SUBTRACT_WITH_BORROW, bat_pkg::OP_BITWISE_AND, bat_pkg::OP_BITWISE_OR,
      bat_pkg::OP_BITWISE_XOR};
    logic [7:0] res [6] = '{8'h96, 8'h97, 8'hE1, 8'h18, 8'h7E, 8'h66};
    @(posedge core_clk);
    carry_in <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 4; j++) begin
        go(ops[i], bat_pkg::bat_src_t'(j), 1'b0, 8'h3C, 8'h5A, 8'h00,
           (j == 1 || j == 3) ? 2'h2 : 2'h1, 3'h1, res[i]);
      end
    end
  endtask : t_arith

  // Logic ops into a direct byte, from the accumulator and from immediate data
  task automatic t_direct;
    bat_pkg::bat_op_t ops [3] = '{bat_pkg::OP_BITWISE_AND, bat_pkg::OP_BITWISE_OR,
      bat_pkg::OP_BITWISE_XOR};
    logic [7:0] res [6] = '{8'h34, 8'h50, 8'hFD, 8'hFF, 8'hC9, 8'hAF};
    for (int i = 0; i < 3; i++) begin
      go(ops[i], bat_pkg::SRC_MAIN, 1'b1, 8'h3C, 8'h5A, 8'hF5, 2'h2, 3'h1,
         res[2*i]);
      chk(write_direct_r, 1'b1);
      go(ops[i], bat_pkg::SRC_IMMEDIATE, 1'b1, 8'h3C, 8'h5A, 8'hF5, 2'h3, 3'h2,
         res[2*i+1]);
      chk(write_direct_r, 1'b1);
    end
  endtask : t_direct

  // Swap, step up and down, pointer step, multiply, divide, decimal correct
  task automatic t_misc;
    @(posedge core_clk);
    carry_in <= 1'b0;
    aux_operand_in <= 8'h10;
    data_pointer16_in <= 16'h12FF;
    go(bat_pkg::OP_NIBBLE_SWAP, bat_pkg::SRC_MAIN, 1'b0, 8'hA5, 8'h00, 8'h00, 2'h1, 3'h1,
       8'h5A);
    go(bat_pkg::OP_PLUS_ONE, bat_pkg::SRC_MAIN, 1'b0, 8'hFF, 8'h00, 8'h00, 2'h1, 3'h1,
       8'h00);
    go(bat_pkg::OP_MINUS_ONE, bat_pkg::SRC_MAIN, 1'b0, 8'h00, 8'h00, 8'h00, 2'h1, 3'h1,
       8'hFF);
    go(bat_pkg::OP_POINTER_PLUS_ONE, bat_pkg::SRC_MAIN, 1'b0, 8'h00, 8'h00, 8'h00, 2'h1, 3'h2,
       8'hxx);
    chk(data_pointer16_r, 16'h1300);
    go(bat_pkg::OP_PRODUCT_AB, bat_pkg::SRC_MAIN, 1'b0, 8'h12, 8'h00, 8'h00, 2'h1, 3'h4,
       8'h20);
    chk(aux_result_r, 8'h01);
    chk({carry_r, aux_carry_r, overflow_r}, 3'b001);
    @(posedge core_clk);
    aux_operand_in <= 8'h07;
    go(bat_pkg::OP_QUOTIENT_AB, bat_pkg::SRC_MAIN, 1'b0, 8'h64, 8'h00, 8'h00, 2'h1, 3'h4,
       8'h0E);
    chk(aux_result_r, 8'h02);
    go(bat_pkg::OP_BCD_CORRECT, bat_pkg::SRC_MAIN, 1'b0, 8'h1B, 8'h00, 8'h00, 2'h1, 3'h1,
       8'h21);
  endtask : t_misc

  // Wait states, divider, both stall causes and a request refused while busy
  task automatic t_timing;
    @(posedge core_clk);
    bus_wait_config <= 3'h1;
    go(bat_pkg::OP_ADD, bat_pkg::SRC_BANK, 1'b0, 8'h3C, 8'h5A, 8'h00, 2'h1, 3'h1,
       8'h96);
    chk({carry_r, aux_carry_r, overflow_r}, 3'b011);
    @(posedge core_clk);
    bus_wait_config <= 3'h3;
    clock_divider_config <= 3'h2;
    go(bat_pkg::OP_ADD, bat_pkg::SRC_BANK, 1'b0, 8'h3C, 8'h5A, 8'h00, 2'h1, 3'h1,
       8'h96);
    @(posedge core_clk);
    bus_wait_config <= 3'h2;
    clock_divider_config <= 3'h1;
    aux_operand_in <= 8'h10;
    poke = 1'b1;
    go(bat_pkg::OP_PRODUCT_AB, bat_pkg::SRC_MAIN, 1'b0, 8'h12, 8'h00, 8'h00, 2'h1, 3'h4,
       8'h20);
    poke = 1'b0;
    @(posedge core_clk);
    bus_wait_config <= 3'h0;
    clock_divider_config <= 3'h0;
    k = 3;
    go(bat_pkg::OP_ADD, bat_pkg::SRC_BANK, 1'b0, 8'h3C, 8'h5A, 8'h00, 2'h1, 3'h1,
       8'h96);
    bc_sel = 1'b1;
    k = 2;
    go(bat_pkg::OP_BITWISE_OR, bat_pkg::SRC_IMMEDIATE, 1'b1, 8'h3C, 8'h5A, 8'hF5, 2'h3, 3'h2,
       8'hFF);
    k = 0;
  endtask : t_timing

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // Main sequence; every input has a value at time zero
  initial begin
    {core_clk, start, to_direct, carry_in, aux_carry_in, overflow_in, poke, bc_sel} = '0;
    {prefetch_queue_stall, branch_cache_miss, bus_wait_config, clock_divider_config} = '0;
    {main_operand_in, src_data, direct_byte_in, aux_operand_in, data_pointer16_in} = '0;
    op_sel = bat_pkg::OP_ADD;
    src_sel = bat_pkg::SRC_BANK;
    {n_fail, check_count, k} = '0;
    rst = 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_arith();
    t_direct();
    t_misc();
    t_timing();
    end_of_test();
  end

  // Hang guard, far beyond the few hundred clocks the run needs
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    end_of_test();
  end
endmodule : tb_bat_core

bind bat_core bat_core_asserts u_asserts (.core_clk, .rst, .start, .op_sel, .src_sel,
  .main_operand_in, .bus_wait_config, .clock_divider_config, .prefetch_queue_stall,
  .branch_cache_miss, .busy_r, .done_r, .result_r, .instr_len_r, .instr_cycles_r,
  .mcycle_end_r, .stretch_r);

`default_nettype wire
